/* rtl/gate_seq_pkg.sv */
/*
 Package for the three-phase gate drive sequencer: timing counts, settings
 and the packed carriers shared by the sequencer ports.
 Assumes a 125 MHz clock; analog comparators arrive as asynchronous levels.
*/
// Behaviour
// - Turn-on waits for opposite gate reported off
// - Optional digital dead time added after handshake
// - High-to-low with inflow adds detector discharge delay
// - Strong pulldown on opposite gate during window
// - Gate fault if threshold missed at window end
// - New PWM command ends active window at once, unless it switches a gate off, which opens a fresh window
// - PWM inputs deglitched against short noise pulses
// - Small pipeline delay on every command
// - Overcurrent only after continuous deglitch time
// - High side compares drain sense to switch node
// - Low side reference depends on amplifier variant
// - Reference select picks source sense or shunt
// - Trip level range per variant type
// - Seven-level decode of current and threshold inputs
// - Four-level decode of mode and gain inputs
// - Selected drive current only inside window
// - Active-low open-drain fault indicator output
package gate_seq_pkg;
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned NUM_PHASES = 3;
    // Detector discharge delay, 200 ns upper figure used
    localparam int unsigned DISCHARGE_NS = 200;
    localparam int unsigned DISCHARGE_CYC = (DISCHARGE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned DEGLITCH_CYC = 4;
    localparam int unsigned PIPE_CYC = 2;
    localparam int unsigned CNT_W = 16;
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
    // Trip level codes in 10 mV steps
    localparam logic [7:0] TRIP_MIN = 8'h06;
    localparam logic [7:0] TRIP_MAX_SERIAL = 8'hc8;
    localparam logic [7:0] TRIP_MAX_PIN = 8'h64;

    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_WAIT_OFF = 3'b001,
        ST_DEAD = 3'b010,
        ST_HIGH = 3'b011,
        ST_LOW = 3'b100
    } bridge_state_e;

    typedef struct packed {
        logic [CNT_W-1:0] drive_window;
        logic [CNT_W-1:0] dead_time;
        logic [CNT_W-1:0] ocp_deglitch;
        logic [7:0] trip_level;
        logic serial_variant;
        logic has_shunt_amp;
        logic lowside_reference_select;
        logic [3:0] gate_current_setting;
    } config_s;

    typedef struct packed {
        logic highside_pwm_input;
        logic lowside_pwm_input;
        logic gs_high_on;
        logic gs_low_on;
        logic phase_inflow;
        logic oc_high;
        logic oc_low_source;
        logic oc_low_shunt;
        logic oc_low_return;
    } phase_in_s;

    typedef struct packed {
        logic gate_high;
        logic gate_low;
        logic strong_pulldown_high;
        logic strong_pulldown_low;
        logic drive_current_active;
        logic gate_fault;
        logic overcurrent;
    } phase_out_s;

    // Seven-level decode: code 0..6 from a level bin
    function automatic logic [2:0] decode7(input logic [2:0] lvl);
        decode7 = (lvl > 3'h6) ? 3'h6 : lvl;
    endfunction

    // Four-level decode
    function automatic logic [1:0] decode4(input logic [1:0] lvl);
        decode4 = lvl;
    endfunction
endpackage

/* rtl/gate_drive_sequencer.sv */
/*
 Gate drive sequencer for three half-bridges with handshake dead time,
 strong pulldown, gate fault and overcurrent deglitch.
 Assumes comparator and PWM inputs are asynchronous; configuration is static.
*/
`timescale 1ns/100ps
module gate_drive_sequencer (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Configuration
    input wire gate_seq_pkg::config_s cfg,
    input wire logic [2:0] gate_current_level,
    input wire logic [2:0] threshold_level,
    input wire logic [1:0] pwm_mode_level,
    input wire logic [1:0] amp_gain_level,
    // Phases
    input wire gate_seq_pkg::phase_in_s [2:0] phase_in,
    output gate_seq_pkg::phase_out_s [2:0] phase_out,
    // Decoded settings
    output logic [2:0] gate_current_code,
    output logic [2:0] threshold_code,
    output logic [1:0] pwm_mode_code,
    output logic [1:0] amp_gain_code,
    output logic [7:0] overcurrent_trip_level,
    // Fault pin
    output logic fault_indicator_n_o,
    output logic fault_indicator_n_oe
);
    import gate_seq_pkg::*;

    // ==========================================================
    // Settings decode
    wire [7:0] trip_max = cfg.serial_variant ? TRIP_MAX_SERIAL : TRIP_MAX_PIN;
    wire [7:0] trip_clamped = (cfg.trip_level < TRIP_MIN) ? TRIP_MIN :
                              (cfg.trip_level > trip_max) ? trip_max : cfg.trip_level;
    // Level pins are asynchronous: two flops before the decode reads them
    logic [9:0] lvl_s1_q, lvl_s2_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lvl_s1_q <= 10'h000;
            lvl_s2_q <= 10'h000;
        end else begin
            lvl_s1_q <= {gate_current_level, threshold_level, pwm_mode_level, amp_gain_level};
            lvl_s2_q <= lvl_s1_q;
        end
    end
    logic [2:0] gcur_q, thr_q;
    logic [1:0] mode_q, gain_q;
    logic [7:0] trip_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gcur_q <= 3'h0;
            thr_q <= 3'h0;
            mode_q <= 2'h0;
            gain_q <= 2'h0;
            trip_q <= TRIP_MIN;
        end else begin
            gcur_q <= decode7(lvl_s2_q[9:7]);
            thr_q <= decode7(lvl_s2_q[6:4]);
            mode_q <= decode4(lvl_s2_q[3:2]);
            gain_q <= decode4(lvl_s2_q[1:0]);
            trip_q <= trip_clamped;
        end
    end
    assign gate_current_code = gcur_q;
    assign threshold_code = thr_q;
    assign pwm_mode_code = mode_q;
    assign amp_gain_code = gain_q;
    assign overcurrent_trip_level = trip_q;

    logic [2:0] fault_any;

    // ==========================================================
    // Per phase sequencer
    genvar p;
    generate
        for (p = 0; p < NUM_PHASES; p++) begin : g_ph
            // Two-flop synchronisers for all analog levels
            logic [8:0] s1_q, s2_q;
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    s1_q <= 9'h000;
                    s2_q <= 9'h000;
                end else begin
                    s1_q <= phase_in[p];
                    s2_q <= s1_q;
                end
            end
            phase_in_s si;
            assign si = s2_q;

            // Deglitch filter: level must hold DEGLITCH_CYC + 1 cycles
            logic [1:0] raw;
            logic [1:0] filt_q, last_q;
            logic [2:0] dg_cnt_q [2];
            assign raw = {si.highside_pwm_input, si.lowside_pwm_input};
            for (genvar b = 0; b < 2; b++) begin : g_dg
                always_ff @(posedge clk) begin
                    if (!rst_n) begin
                        last_q[b] <= 1'b0;
                        filt_q[b] <= 1'b0;
                        dg_cnt_q[b] <= 3'h0;
                    end else begin
                        last_q[b] <= raw[b];
                        if (raw[b] != last_q[b]) begin
                            dg_cnt_q[b] <= 3'h0;
                        end else if (dg_cnt_q[b] == 3'(DEGLITCH_CYC - 1)) begin
                            filt_q[b] <= raw[b];
                        end else begin
                            dg_cnt_q[b] <= dg_cnt_q[b] + 3'h1;
                        end
                    end
                end
            end

            // Pipeline delay ahead of the sequencer
            logic [1:0] pipe_q [PIPE_CYC];
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    for (int i = 0; i < PIPE_CYC; i++) pipe_q[i] <= 2'b00;
                end else begin
                    pipe_q[0] <= filt_q;
                    for (int i = 1; i < PIPE_CYC; i++) pipe_q[i] <= pipe_q[i-1];
                end
            end
            // Both high commanded counts as off: shoot-through guard
            wire [1:0] cmd = pipe_q[PIPE_CYC-1];
            wire want_h = cmd == 2'b10;
            wire want_l = cmd == 2'b01;
            logic [1:0] cmd_q;
            wire cmd_chg = cmd != cmd_q;

            bridge_state_e st_q, st_d;
            logic target_h_q, target_l_q;
            logic [CNT_W-1:0] dcnt_q, wcnt_q;
            logic win_q, hl_q;
            logic gh_q, gl_q, pdh_q, pdl_q, drv_q, gf_q, oc_q;

            wire opp_off = target_h_q ? !si.gs_low_on : !si.gs_high_on;
            wire dead_done = dcnt_q == CNT_RESET;
            // Expected gate level checked at window end
            wire gs_ok = (gh_q == si.gs_high_on) && (gl_q == si.gs_low_on);
            wire win_end = win_q && (wcnt_q == CNT_RESET);

            always_comb begin
                st_d = st_q;
                unique case (st_q)
                    ST_OFF, ST_HIGH, ST_LOW: begin
                        if (cmd_chg) st_d = (want_h || want_l) ? ST_WAIT_OFF : ST_OFF;
                    end
                    ST_WAIT_OFF: begin
                        if (cmd_chg) st_d = (want_h || want_l) ? ST_WAIT_OFF : ST_OFF;
                        else if (opp_off) st_d = ST_DEAD;
                    end
                    ST_DEAD: begin
                        if (cmd_chg) st_d = (want_h || want_l) ? ST_WAIT_OFF : ST_OFF;
                        else if (dead_done) st_d = target_h_q ? ST_HIGH : ST_LOW;
                    end
                    default: st_d = ST_OFF;
                endcase
            end

            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    st_q <= ST_OFF;
                    cmd_q <= 2'b00;
                    target_h_q <= 1'b0;
                    target_l_q <= 1'b0;
                    dcnt_q <= CNT_RESET;
                    hl_q <= 1'b0;
                end else begin
                    st_q <= st_d;
                    cmd_q <= cmd;
                    if (cmd_chg) begin
                        target_h_q <= want_h;
                        target_l_q <= want_l;
                        hl_q <= gh_q && want_l && si.phase_inflow;
                    end
                    if (st_d == ST_DEAD && st_q != ST_DEAD) begin
                        // Handshake plus digital dead time, plus discharge delay when hl_q is set
                        dcnt_q <= cfg.dead_time + (hl_q ? CNT_W'(DISCHARGE_CYC) : CNT_RESET);
                    end else if (dcnt_q != CNT_RESET) begin
                        dcnt_q <= dcnt_q - 16'h0001;
                    end
                end
            end

            // Gate outputs; opposite gates exclusive by state encoding
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    gh_q <= 1'b0;
                    gl_q <= 1'b0;
                end else begin
                    gh_q <= (st_d == ST_HIGH);
                    gl_q <= (st_d == ST_LOW) && (st_d != ST_HIGH);
                end
            end

            // Drive window: starts on gate edge (which wins over a new command), cut by a new command that moves no gate
            wire gate_edge = (gh_q != (st_d == ST_HIGH)) || (gl_q != (st_d == ST_LOW));
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    win_q <= 1'b0;
                    wcnt_q <= CNT_RESET;
                    pdh_q <= 1'b0;
                    pdl_q <= 1'b0;
                    drv_q <= 1'b0;
                    gf_q <= 1'b0;
                end else begin
                    if (gate_edge && cfg.drive_window != CNT_RESET) begin
                        win_q <= 1'b1;
                        wcnt_q <= cfg.drive_window - 16'h0001;
                        pdl_q <= (st_d == ST_HIGH) || (gh_q && st_d != ST_HIGH);
                        pdh_q <= (st_d == ST_LOW) || (gl_q && st_d != ST_LOW);
                        drv_q <= 1'b1;
                    end else if (cmd_chg || win_end) begin
                        win_q <= 1'b0;
                        pdh_q <= 1'b0;
                        pdl_q <= 1'b0;
                        drv_q <= 1'b0;
                    end else if (win_q) begin
                        wcnt_q <= wcnt_q - 16'h0001;
                    end
                    // Sticky until reset; window length chosen by software
                    if (win_end && !cmd_chg && !gs_ok) gf_q <= 1'b1;
                end
            end

            // Overcurrent deglitch
            wire lo_ref = cfg.has_shunt_amp ?
                          (cfg.serial_variant && cfg.lowside_reference_select ? si.oc_low_shunt
                                                                               : si.oc_low_source)
                          : si.oc_low_return;
            wire oc_now = (gh_q && si.oc_high) || (gl_q && lo_ref);
            logic [CNT_W-1:0] ocnt_q;
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    ocnt_q <= CNT_RESET;
                    oc_q <= 1'b0;
                end else begin
                    if (!oc_now) begin
                        ocnt_q <= CNT_RESET;
                    end else if (ocnt_q >= cfg.ocp_deglitch) begin
                        oc_q <= 1'b1;
                    end else begin
                        ocnt_q <= ocnt_q + 16'h0001;
                    end
                end
            end

            assign phase_out[p] = '{gate_high: gh_q, gate_low: gl_q, strong_pulldown_high: pdh_q,
                                    strong_pulldown_low: pdl_q, drive_current_active: drv_q,
                                    gate_fault: gf_q, overcurrent: oc_q};
            assign fault_any[p] = gf_q | oc_q;
        end
    endgenerate

    // ==========================================================
    // Open-drain fault pin: drive low while any fault stands
    logic fault_oe_q;
    always_ff @(posedge clk) begin
        if (!rst_n) fault_oe_q <= 1'b0;
        else fault_oe_q <= |fault_any;
    end
    assign fault_indicator_n_o = 1'b0;
    assign fault_indicator_n_oe = fault_oe_q;
endmodule // gate_drive_sequencer

/* verification/half_bridge_model.sv */
/*
 Model of one external half-bridge: gate monitors follow the gates.
 Assumes gate levels come from the sequencer on the same clock.
*/
`timescale 1ns/100ps
module half_bridge_model #(
    parameter int LAG = 3
) (
    // Clock
    input wire logic clk,
    // Gates and fault injection
    input wire logic gate_high,
    input wire logic gate_low,
    input wire logic stuck_off,
    // Monitors
    output logic gs_high_on,
    output logic gs_low_on
);
    logic [LAG-1:0] hi_q = '0;
    logic [LAG-1:0] lo_q = '0;
    // Gate charge takes LAG cycles, well inside the window
    always_ff @(posedge clk) begin
        hi_q <= {hi_q[LAG-2:0], gate_high & ~stuck_off};
        lo_q <= {lo_q[LAG-2:0], gate_low};
    end
    assign gs_high_on = hi_q[LAG-1];
    assign gs_low_on = lo_q[LAG-1];
endmodule // half_bridge_model

/* verification/gate_seq_checker.sv */
/*
 Checker for the gate drive sequencer ports.
 Assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/100ps
module gate_seq_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Watched ports
    input wire gate_seq_pkg::config_s cfg,
    input wire logic [2:0] gate_current_level,
    input wire gate_seq_pkg::phase_in_s [2:0] phase_in,
    input wire gate_seq_pkg::phase_out_s [2:0] phase_out,
    input wire logic [2:0] gate_current_code,
    input wire logic [7:0] overcurrent_trip_level,
    input wire logic fault_indicator_n_o,
    input wire logic fault_indicator_n_oe
);
    import gate_seq_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // Helper logic
    logic [15:0] run_q;
    logic [1:0] gates_q;
    logic any_fault;
    assign any_fault = |{phase_out[0].gate_fault, phase_out[1].gate_fault, phase_out[2].gate_fault,
        phase_out[0].overcurrent, phase_out[1].overcurrent, phase_out[2].overcurrent};
    // Restart at every phase 0 gate edge, since each edge opens a fresh window
    always_ff @(posedge clk) begin
        gates_q <= {phase_out[0].gate_high, phase_out[0].gate_low};
        if (!rst_n || !phase_out[0].drive_current_active) run_q <= 16'h0000;
        else if (gates_q != {phase_out[0].gate_high, phase_out[0].gate_low}) run_q <= 16'h0000;
        else run_q <= run_q + 16'h0001;
    end
    // ==========================================
    // Per-phase properties
    for (genvar p = 0; p < 3; p++) begin : g_ph
        a_no_shoot_through: assert property (!(phase_out[p].gate_high && phase_out[p].gate_low))
            else $error("both gates on");
        a_pulldown_opposite: assert property ($rose(phase_out[p].gate_high) |->
            ##[0:1] phase_out[p].strong_pulldown_low)
            else $error("no pulldown on low gate");
        a_handshake_wait: assert property ($rose(phase_out[p].gate_high) |-> !$past(phase_in[p].gs_low_on, 2))
            else $error("high gate on before low off");
        a_drive_in_window: assert property (phase_out[p].drive_current_active |->
            phase_out[p].strong_pulldown_low || phase_out[p].strong_pulldown_high)
            else $error("drive current outside window");
        a_fault_at_end: assert property ($rose(phase_out[p].gate_fault) |->
            $past(phase_out[p].drive_current_active) || $past(phase_out[p].drive_current_active, 2))
            else $error("gate fault not at window end");
    end
    // ==========================================
    // Shared properties
    a_window_bound: assert property (run_q <= cfg.drive_window)
        else $error("window longer than set");
    a_fault_pin: assert property ($rose(any_fault) |=> fault_indicator_n_oe && !fault_indicator_n_o)
        else $error("fault pin not pulled");
    a_code_clamp: assert property ($past(rst_n, 3) |-> gate_current_code ==
        (($past(gate_current_level, 3) > 3'h6) ? 3'h6 : $past(gate_current_level, 3)))
        else $error("seven level decode wrong");
    a_trip_range: assert property (overcurrent_trip_level >= 8'h06 &&
        overcurrent_trip_level <= (cfg.serial_variant ? 8'hc8 : 8'h64))
        else $error("trip level out of range");
endmodule // gate_seq_checker

bind gate_drive_sequencer gate_seq_checker gate_seq_checker_i (.clk(clk), .rst_n(rst_n), .cfg(cfg),
    .gate_current_level(gate_current_level), .phase_in(phase_in), .phase_out(phase_out),
    .gate_current_code(gate_current_code), .overcurrent_trip_level(overcurrent_trip_level),
    .fault_indicator_n_o(fault_indicator_n_o), .fault_indicator_n_oe(fault_indicator_n_oe));

/* verification/gate_drive_sequencer_tb.sv */
/*
 Self-checking bench for the gate drive sequencer, phase 0 exercised, phases 1 and 2 for low side trips.
 Assumes half_bridge_model stands behind every phase.
*/
`timescale 1ns/100ps
module gate_drive_sequencer_tb;
    import gate_seq_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic stuck = 1'b0;
    logic [2:0] gcl = 3'h7;
    wire [2:0] gsh, gsl;
    logic [2:0] gcode, tcode;
    logic [1:0] mcode, acode;
    logic [7:0] trip;
    logic f_o, f_oe;
    config_s cfg;
    phase_in_s [2:0] pin, pi;
    phase_out_s [2:0] po;
    int failures = 0;
    int num_checks = 0;
    int l0, l1, n;
    always #4 clk = ~clk;
    gate_drive_sequencer gate_drive_sequencer_i (.clk(clk), .rst_n(rst_n), .cfg(cfg), .gate_current_level(gcl),
        .threshold_level(3'h3), .pwm_mode_level(2'h2), .amp_gain_level(2'h1), .phase_in(pi), .phase_out(po),
        .gate_current_code(gcode), .threshold_code(tcode), .pwm_mode_code(mcode), .amp_gain_code(acode),
        .overcurrent_trip_level(trip), .fault_indicator_n_o(f_o), .fault_indicator_n_oe(f_oe));
    for (genvar i = 0; i < 3; i++) begin : g_hb
        half_bridge_model half_bridge_model_i (.clk(clk), .gate_high(po[i].gate_high), .gate_low(po[i].gate_low),
            .stuck_off(stuck), .gs_high_on(gsh[i]), .gs_low_on(gsl[i]));
    end
    always_comb begin
        pi = pin;
        for (int i = 0; i < 3; i++) begin
            pi[i].gs_high_on = gsh[i];
            pi[i].gs_low_on = gsl[i];
        end
    end
    // ==========================================
    // Tasks
    task automatic check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic cmd(input logic h, input logic l);
        @(posedge clk);
        pin[0].highside_pwm_input <= h;
        pin[0].lowside_pwm_input <= l;
    endtask
    // Latency to the commanded gate, then fault state after the window
    task automatic measure(input logic h, input logic l, input logic flt, output int lat);
        cmd(h, l);
        lat = 0;
        while ((h ? po[0].gate_high : po[0].gate_low) !== 1'b1 && lat < 200) begin
            @(negedge clk);
            lat++;
        end
        check(lat < 200, "gate never switched");
        if (lat >= 200) final_report();
        check(h ? po[0].strong_pulldown_low : po[0].strong_pulldown_high, "no pulldown");
        repeat (40) @(negedge clk);
        check(po[0].drive_current_active === 1'b0, "drive current held");
        check(po[0].gate_fault === flt && f_oe === flt, "gate fault state");
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        check(1'b0, "timeout");
        final_report();
    end
    // ==========================================
    // Main sequence
    initial begin
        pin = '0;
        cfg = '0;
        cfg.drive_window = 16'h0008;
        cfg.dead_time = 16'h0002;
        cfg.ocp_deglitch = 16'h0004;
        cfg.trip_level = 8'h02;
        cfg.serial_variant = 1'b1;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(negedge clk);
        check(trip === 8'h06, "trip low clamp");
        check(gcode === 3'h6 && tcode === 3'h3, "seven level decode");
        check(mcode === 2'h2 && acode === 2'h1, "four level decode");
        check(po[0] === '0 && f_oe === 1'b0, "idle after reset");
        cmd(1'b1, 1'b0);
        cmd(1'b1, 1'b0);
        cmd(1'b0, 1'b0);
        repeat (30) @(negedge clk);
        check(po[0].gate_high === 1'b0, "glitch passed");
        measure(1'b1, 1'b0, 1'b0, n);
        check(n >= PIPE_CYC + DEGLITCH_CYC, "no input delay");
        measure(1'b0, 1'b1, 1'b0, l0);
        measure(1'b1, 1'b0, 1'b0, n);
        @(posedge clk) pin[0].phase_inflow <= 1'b1;
        measure(1'b0, 1'b1, 1'b0, l1);
        check(l1 == l0 + int'(DISCHARGE_CYC), "discharge delay");
        @(posedge clk) pin[0].phase_inflow <= 1'b0;
        cfg.dead_time <= 16'h0006;
        measure(1'b1, 1'b0, 1'b0, n);
        measure(1'b0, 1'b1, 1'b0, l1);
        check(l1 == l0 + 4, "digital dead time");
        @(posedge clk) cfg.dead_time <= 16'h0002;
        cfg.drive_window <= 16'h0040;
        cmd(1'b1, 1'b0);
        for (n = 0; po[0].gate_high !== 1'b1 && n < 200; n++) @(negedge clk);
        cmd(1'b0, 1'b1);
        for (l1 = 0; po[0].gate_low !== 1'b1 && l1 < 200; l1++) @(negedge clk);
        check(l1 == l0 && po[0].strong_pulldown_high === 1'b1, "window stretched command");
        check(po[0].drive_current_active === 1'b1, "long window cut short");
        repeat (80) @(negedge clk);
        check(po[0].drive_current_active === 1'b0 && po[0].gate_fault === 1'b0, "long window stuck");
        @(posedge clk) cfg.drive_window <= 16'h0008;
        cmd(1'b1, 1'b1);
        repeat (30) @(negedge clk);
        check(po[0].gate_high === 1'b0 && po[0].gate_low === 1'b0, "both on");
        @(posedge clk) stuck <= 1'b1;
        measure(1'b1, 1'b0, 1'b1, n);
        @(posedge clk) rst_n <= 1'b0;
        stuck <= 1'b0;
        cfg.serial_variant <= 1'b0;
        cfg.trip_level <= 8'hff;
        pin[0].highside_pwm_input <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(negedge clk);
        check(trip === 8'h64 && po[0].gate_fault === 1'b0, "pin trip clamp");
        measure(1'b1, 1'b0, 1'b0, n);
        @(posedge clk) pin[0].oc_high <= 1'b1;
        @(posedge clk) pin[0].oc_high <= 1'b0;
        repeat (20) @(negedge clk);
        check(po[0].overcurrent === 1'b0, "short trip accepted");
        @(posedge clk) pin[0].oc_high <= 1'b1;
        repeat (20) @(negedge clk);
        check(po[0].overcurrent === 1'b1 && f_oe === 1'b1, "high side trip missed");
        @(posedge clk) pin[1].lowside_pwm_input <= 1'b1;
        pin[1].oc_low_source <= 1'b1;
        pin[1].oc_low_shunt <= 1'b1;
        repeat (40) @(negedge clk);
        check(po[1].gate_low === 1'b1 && po[1].overcurrent === 1'b0, "low side used sense path");
        @(posedge clk) pin[1].oc_low_return <= 1'b1;
        repeat (20) @(negedge clk);
        check(po[1].overcurrent === 1'b1, "low side return trip missed");
        @(posedge clk) cfg.has_shunt_amp <= 1'b1;
        cfg.serial_variant <= 1'b1;
        cfg.lowside_reference_select <= 1'b1;
        pin[2].lowside_pwm_input <= 1'b1;
        pin[2].oc_low_source <= 1'b1;
        pin[2].oc_low_return <= 1'b1;
        repeat (40) @(negedge clk);
        check(po[2].gate_low === 1'b1 && po[2].overcurrent === 1'b0, "reference select ignored");
        @(posedge clk) pin[2].oc_low_shunt <= 1'b1;
        repeat (20) @(negedge clk);
        check(po[2].overcurrent === 1'b1, "shunt reference trip missed");
        final_report();
    end
endmodule // gate_drive_sequencer_tb
